// *** hw/arpp_top.sv ***
// sample buffer and per-channel averaging, correction and limit checks
// assumes samples, register accesses and result sink share i_clk
`timescale 1ns/1ps
`default_nettype none

// plain valid/ready fifo, all state in one registered struct
module arpp_fifo #(
   parameter int W = 19,
   parameter int DEPTH = 8
) (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_nrst,
   // filling side
   input wire logic i_in_valid,
   output logic o_in_ready,
   input wire logic [W-1:0] i_in_data,
   // draining side
   output logic o_out_valid,
   input wire logic i_out_ready,
   output logic [W-1:0] o_out_data
);
   localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CNT_W = $clog2(DEPTH + 1);
   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem; // storage words
      logic [PTR_W-1:0] wr; // write index
      logic [PTR_W-1:0] rd; // read index
      logic [CNT_W-1:0] cnt; // words held
      logic ready; // not full
      logic valid; // not empty
   } arpp_fifo_t;
   arpp_fifo_t s, next_s;
   logic push, pop;

   // pointer and count update; full and empty kept as flops
   always_comb begin
      next_s = s;
      push = i_in_valid & s.ready;
      pop = s.valid & i_out_ready;
      if (push) begin
         next_s.mem[s.wr] = i_in_data;
         next_s.wr = (s.wr == PTR_W'(DEPTH - 1)) ? '0 : s.wr + 1'h1;
      end
      if (pop) begin
         next_s.rd = (s.rd == PTR_W'(DEPTH - 1)) ? '0 : s.rd + 1'h1;
      end
      if (push && !pop) begin
         next_s.cnt = s.cnt + 1'h1;
      end else if (pop && !push) begin
         next_s.cnt = s.cnt - 1'h1;
      end
      next_s.ready = (next_s.cnt != CNT_W'(DEPTH));
      next_s.valid = (next_s.cnt != '0);
   end

   // state register with synchronous reset to empty
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         s <= '0;
         s.ready <= 1'h1;
      end else begin
         s <= next_s;
      end
   end

   assign o_in_ready = s.ready;
   assign o_out_valid = s.valid;
   assign o_out_data = s.mem[s.rd];
endmodule

module arpp_top import arpp_pkg::*; #(
   parameter int FIFO_DEPTH = FIFO_DEPTH_DEF,
   parameter int AUTO_CYC = AUTO_PERIOD_CYC
) (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_nrst,
   // conversions from the core
   input wire logic i_smp_valid,
   output logic o_smp_ready,
   input wire logic [CH_W-1:0] i_smp_chan,
   input wire logic [SMP_W-1:0] i_smp_data,
   // internal trigger and multiplexer hold
   output logic o_convert_trigger,
   output logic o_mux_lock,
   output logic [CH_W-1:0] o_mux_chan,
   // corrected results
   output logic o_res_valid,
   input wire logic i_res_ready,
   output logic [CH_W-1:0] o_res_chan,
   output logic [RES_W-1:0] o_res_data,
   output logic [1:0] o_res_ratio,
   // indicators
   output logic o_busy,
   output logic o_any_limit_alert,
   // register port from the serial interface
   input wire logic i_reg_cfg_mode,
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   input wire logic [REG_ADDR_W-1:0] i_reg_addr,
   input wire logic [REG_DATA_W-1:0] i_reg_wdata,
   output logic [REG_DATA_W-1:0] o_reg_rdata,
   output logic o_reg_rvalid
);
   typedef struct packed {
      arpp_cfg_t [CH-1:0] cfg; // channel_config_reg
      logic [CH-1:0][GAIN_W-1:0] gain; // channel_gain_word
      logic [CH-1:0][GAIN_W-1:0] offs; // channel_offset_word
      logic [CH-1:0][LIM_W-1:0] hi_lim; // channel_high_limit
      logic [CH-1:0][LIM_W-1:0] lo_lim; // channel_low_limit
      logic [CH-1:0][HYST_W-1:0] hyst; // channel_hysteresis
      logic [1:0] seq_mode; // sequencer selection
      logic alert_mode; // 1: flags clear on read only
      logic busy_en; // busy indicator enable
      logic auto_en; // autonomous conversion
      logic [CH-1:0] hi_flag; // high_limit_flag per channel
      logic [CH-1:0] lo_flag; // low_limit_flag per channel
      logic any_alert; // any_limit_alert
      arpp_phase_t phase; // averaging state
      logic [CH_W-1:0] lock_chan; // channel held by the mux
      logic [1:0] lock_ratio; // ratio code latched at lock
      logic [5:0] cnt; // conversions taken so far
      logic [ACC_W-1:0] acc; // running sum
      logic res_valid;
      logic [CH_W-1:0] res_chan;
      logic [RES_W-1:0] res_data;
      logic [1:0] res_ratio;
      logic busy;
      logic [15:0] trig_cnt; // cycles to next trigger
      logic trig;
      logic [REG_DATA_W-1:0] rdata;
      logic rvalid;
   } arpp_state_t;

   // reset image: unity gain, widest upper limit, everything else zero
   function automatic arpp_state_t fn_rst();
      arpp_state_t r;
      r = '0;
      for (int i = 0; i < CH; i++) begin
         r.gain[i] = GAIN_RST;
         r.offs[i] = OFFSET_RST;
         r.hi_lim[i] = HIGH_RST;
         r.lo_lim[i] = LOW_RST;
      end
      r.alert_mode = 1'h0; // hysteresis clearing by default
      return r;
   endfunction
   localparam arpp_state_t ARPP_RST = fn_rst();

   // offset, gain and clamp on one averaged sum
   function automatic logic signed [MATH_W-1:0] fn_correct(
      input logic [ACC_W-1:0] acc,
      input logic [1:0] k,
      input logic bip,
      input logic [GAIN_W-1:0] gain,
      input logic [GAIN_W-1:0] offs
   );
      logic signed [MATH_W-1:0] one, avg, b, prod, top, bot;
      one = 40'sh1;
      // keep one extra bit per factor four
      avg = $signed({{(MATH_W - ACC_W){acc[ACC_W-1]}}, acc}) >>> k;
      // offset msb lines up with result msb minus three
      b = $signed({{(MATH_W - GAIN_W){offs[GAIN_W-1]}}, offs})
         >>> (2'(OFFS_TOP) - k);
      // correction is never bypassed
      prod = ((avg + b) * $signed({{(MATH_W - GAIN_W){1'h0}}, gain}))
         >>> GAIN_FRAC;
      top = bip ? (one <<< (SMP_W - 1 + k)) - one
         : (one <<< (SMP_W + k)) - one;
      bot = bip ? -(one <<< (SMP_W - 1 + k)) : '0;
      // clamp rather than wrap
      if (prod > top) begin
         prod = top;
      end else if (prod < bot) begin
         prod = bot;
      end
      return prod;
   endfunction

   // a 12-bit field scaled to the result's twelve msbs
   function automatic logic signed [MATH_W-1:0] fn_scale(
      input logic [LIM_W-1:0] v,
      input logic sext,
      input logic [1:0] k
   );
      logic signed [MATH_W-1:0] e;
      e = $signed({{(MATH_W - LIM_W){sext & v[LIM_W-1]}}, v});
      return e <<< (LIM_SHIFT + k);
   endfunction

   arpp_state_t s, next_s;
   // fifo draining side
   logic f_valid, f_pop;
   logic [CH_W+SMP_W-1:0] f_data;
   logic [CH_W-1:0] f_chan;
   logic [SMP_W-1:0] f_smp;
   // averaging scratch values
   logic [CH_W-1:0] ch;
   logic [1:0] k;
   logic [ACC_W-1:0] acc0, acc_new;
   logic take, last, bip, td;
   logic signed [MATH_W-1:0] res, up, dn, hy;
   logic [CH-1:0] set_hi, set_lo, clr_hi, clr_lo;
   logic [REG_DATA_W-1:0] rd_mux;
   logic [CH_W-1:0] wch;

   // pop only when the result slot is free or being emptied
   assign f_pop = f_valid & (~s.res_valid | i_res_ready);
   assign f_chan = f_data[CH_W+SMP_W-1:SMP_W];
   assign f_smp = f_data[SMP_W-1:0];

   // buffer absorbs bursts while the result sink stalls
   arpp_fifo #(
      .W(CH_W + SMP_W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .i_clk(i_clk),
      .i_nrst(i_nrst),
      .i_in_valid(i_smp_valid),
      .o_in_ready(o_smp_ready),
      .i_in_data({i_smp_chan, i_smp_data}),
      .o_out_valid(f_valid),
      .i_out_ready(f_pop),
      .o_out_data(f_data)
   );

   // register read multiplexer
   always_comb begin
      rd_mux = '0;
      wch = i_reg_addr[5:3];
      if (!i_reg_addr[REG_GLOBAL_BIT]) begin
         unique case (i_reg_addr[2:0])
            RCH_CONFIG: rd_mux = REG_DATA_W'(s.cfg[wch]);
            RCH_GAIN: rd_mux = s.gain[wch];
            RCH_OFFSET: rd_mux = s.offs[wch];
            RCH_HIGH: rd_mux = REG_DATA_W'(s.hi_lim[wch]);
            RCH_LOW: rd_mux = REG_DATA_W'(s.lo_lim[wch]);
            RCH_HYST: rd_mux = REG_DATA_W'(s.hyst[wch]);
            default: rd_mux = '0; // holes read as zero
         endcase
      end else begin
         unique case (i_reg_addr)
            REG_SETUP: rd_mux = REG_DATA_W'({s.auto_en, s.busy_en,
               s.alert_mode, s.seq_mode});
            REG_ALERT_A: rd_mux = REG_DATA_W'(s.hi_flag);
            REG_ALERT_B: rd_mux = REG_DATA_W'(s.lo_flag);
            REG_STATUS: rd_mux = REG_DATA_W'({s.busy, s.any_alert});
            default: rd_mux = '0; // unmapped reads as zero
         endcase
      end
   end

   // next-state logic for registers, trigger, averager and flags
   always_comb begin
      next_s = s;
      next_s.trig = 1'h0;
      next_s.rvalid = 1'h0;
      set_hi = '0;
      set_lo = '0;
      clr_hi = '0;
      clr_lo = '0;
      ch = '0;
      k = '0;
      acc0 = '0;
      acc_new = '0;
      take = 1'h0;
      last = 1'h0;
      bip = 1'h0;
      td = 1'h0;
      res = '0;
      up = '0;
      dn = '0;
      hy = '0;
      // register writes; flag and status words are read-only
      if (i_reg_wr) begin
         if (!i_reg_addr[REG_GLOBAL_BIT]) begin
            unique case (i_reg_addr[2:0])
               RCH_CONFIG: next_s.cfg[wch] = arpp_cfg_t'(i_reg_wdata[3:0]);
               RCH_GAIN: next_s.gain[wch] = i_reg_wdata;
               RCH_OFFSET: next_s.offs[wch] = i_reg_wdata;
               RCH_HIGH: next_s.hi_lim[wch] = i_reg_wdata[LIM_W-1:0];
               RCH_LOW: next_s.lo_lim[wch] = i_reg_wdata[LIM_W-1:0];
               RCH_HYST: next_s.hyst[wch] = i_reg_wdata[HYST_W-1:0];
               default: ; // holes ignore writes
            endcase
         end else if (i_reg_addr == REG_SETUP) begin
            next_s.seq_mode = i_reg_wdata[SETUP_SEQ_LSB+:2];
            next_s.alert_mode = i_reg_wdata[SETUP_ALERT_MODE_BIT];
            next_s.busy_en = i_reg_wdata[SETUP_BUSY_EN_BIT];
            next_s.auto_en = i_reg_wdata[SETUP_AUTO_BIT];
         end
      end
      // reads answer next cycle; outside config mode they give zero
      if (i_reg_rd) begin
         next_s.rvalid = 1'h1;
         next_s.rdata = '0;
         if (i_reg_cfg_mode) begin
            next_s.rdata = rd_mux;
            if (i_reg_addr == REG_ALERT_A) begin
               clr_hi = '1; // read clears
            end
            if (i_reg_addr == REG_ALERT_B) begin
               clr_lo = '1;
            end
         end
      end
      // free-running internal trigger in autonomous mode
      if (s.auto_en) begin
         if (s.trig_cnt == '0) begin
            next_s.trig = 1'h1;
            next_s.trig_cnt = 16'(AUTO_CYC - 1);
         end else begin
            next_s.trig_cnt = s.trig_cnt - 16'h1;
         end
      end else begin
         next_s.trig_cnt = '0;
      end
      // result leaves when the sink takes it
      if (s.res_valid && i_res_ready) begin
         next_s.res_valid = 1'h0;
      end
      // averaging: same path whatever made the trigger
      if (f_pop) begin
         if (s.phase == ARPP_IDLE) begin
            ch = f_chan;
            // standard sequencer shares channel zero ratio
            // others use the channel's own ratio
            k = (s.seq_mode == SEQ_STD) ?
               s.cfg[0].averaging_ratio_field :
               s.cfg[f_chan].averaging_ratio_field;
            acc0 = '0;
            take = 1'h1;
         end else begin
            ch = s.lock_chan;
            k = s.lock_ratio;
            acc0 = s.acc;
            // stray channels are dropped while locked
            take = (f_chan == s.lock_chan);
         end
         bip = s.cfg[ch].bipolar;
         acc_new = acc0 + (bip ?
            {{(ACC_W - SMP_W){f_smp[SMP_W-1]}}, f_smp} :
            {{(ACC_W - SMP_W){1'h0}}, f_smp});
         // ratio 1 finishes at once, else after 4^k samples
         last = (k == 2'h0) || (s.cnt == 6'((1 << (2 * k)) - 1));
         if (take && !last) begin
            next_s.phase = ARPP_ACCUM; // hold the mux
            next_s.lock_chan = ch;
            next_s.lock_ratio = k;
            next_s.cnt = s.cnt + 6'h1;
            next_s.acc = acc_new;
         end else if (take) begin
            next_s.phase = ARPP_IDLE;
            next_s.cnt = '0;
            next_s.acc = '0;
            res = fn_correct(acc_new, k, bip, s.gain[ch], s.offs[ch]);
            next_s.res_valid = 1'h1;
            next_s.res_chan = ch;
            next_s.res_data = res[RES_W-1:0];
            next_s.res_ratio = k;
            // enable from channel zero under standard sequencer
            td = (s.seq_mode == SEQ_STD) ?
               s.cfg[0].limit_check_enable :
               s.cfg[ch].limit_check_enable;
            up = fn_scale(s.hi_lim[ch], bip, k);
            dn = fn_scale(s.lo_lim[ch], bip, k);
            hy = fn_scale({{(LIM_W - HYST_W){1'h0}}, s.hyst[ch]},
               1'h0, k);
            // compared only against the averaged result
            if (td) begin
               set_hi[ch] = (res >= up);
               set_lo[ch] = (res <= dn);
               if (!s.alert_mode) begin
                  // hysteresis release
                  clr_hi[ch] = clr_hi[ch] | (res < up - hy);
                  clr_lo[ch] = clr_lo[ch] | (res > dn + hy);
               end
            end
         end
      end
      // a new hit wins over a clear in the same cycle
      next_s.hi_flag = (s.hi_flag & ~clr_hi) | set_hi;
      next_s.lo_flag = (s.lo_flag & ~clr_lo) | set_lo;
      next_s.any_alert = |{next_s.hi_flag, next_s.lo_flag};
      // busy rises with pending conversions, falls with the result
      next_s.busy = s.busy_en &
         ((next_s.phase == ARPP_ACCUM) | (f_valid & ~f_pop));
   end

   // one register for the whole state, synchronous reset
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         s <= ARPP_RST;
      end else begin
         s <= next_s;
      end
   end

   // every output is a flop of the state
   assign o_convert_trigger = s.trig;
   assign o_mux_lock = (s.phase == ARPP_ACCUM);
   assign o_mux_chan = s.lock_chan;
   assign o_res_valid = s.res_valid;
   assign o_res_chan = s.res_chan;
   assign o_res_data = s.res_data;
   assign o_res_ratio = s.res_ratio;
   assign o_busy = s.busy;
   assign o_any_limit_alert = s.any_alert;
   assign o_reg_rdata = s.rdata;
   assign o_reg_rvalid = s.rvalid;
endmodule

`default_nettype wire

// *** hw/arpp_pkg.sv ***
// shared constants and types for the result post-processing path
// assumes one 100 MHz clock domain and a synchronous active-low reset
package arpp_pkg;
   // geometry
   localparam int CH = 8; // analog channels
   localparam int CH_W = 3; // channel index width
   localparam int SMP_W = 16; // raw conversion width
   localparam int RES_W = 19; // widest averaged result
   localparam int ACC_W = 23; // 64 unsigned samples plus sign room
   localparam int MATH_W = 40; // correction arithmetic width
   localparam int GAIN_W = 16; // gain and offset word width
   localparam int GAIN_FRAC = 15; // gain word fraction bits
   localparam int OFFS_TOP = 3; // offset msb sits this far below result msb
   localparam int LIM_W = 12; // limit field width
   localparam int LIM_SHIFT = 4; // limit lsb position at ratio 1
   localparam int HYST_W = 8; // hysteresis field width
   localparam int FIFO_DEPTH_DEF = 8; // sample buffer depth
   // register port
   localparam int REG_ADDR_W = 7;
   localparam int REG_DATA_W = 16;
   localparam int REG_GLOBAL_BIT = 6; // set: global register, clear: channel
   localparam logic [2:0] RCH_CONFIG = 3'h0;
   localparam logic [2:0] RCH_GAIN = 3'h1;
   localparam logic [2:0] RCH_OFFSET = 3'h2;
   localparam logic [2:0] RCH_HIGH = 3'h3;
   localparam logic [2:0] RCH_LOW = 3'h4;
   localparam logic [2:0] RCH_HYST = 3'h5;
   localparam logic [REG_ADDR_W-1:0] REG_SETUP = 7'h40;
   localparam logic [REG_ADDR_W-1:0] REG_ALERT_A = 7'h41;
   localparam logic [REG_ADDR_W-1:0] REG_ALERT_B = 7'h42;
   localparam logic [REG_ADDR_W-1:0] REG_STATUS = 7'h43;
   // setup register fields
   localparam int SETUP_SEQ_LSB = 0; // two bits
   localparam int SETUP_ALERT_MODE_BIT = 2;
   localparam int SETUP_BUSY_EN_BIT = 3;
   localparam int SETUP_AUTO_BIT = 4;
   // sequencer mode codes
   localparam logic [1:0] SEQ_STD = 2'h0;
   localparam logic [1:0] SEQ_ADV = 2'h1;
   localparam logic [1:0] SEQ_CMD2 = 2'h2;
   localparam logic [1:0] SEQ_CMD1 = 2'h3;
   // reset values
   localparam logic [GAIN_W-1:0] GAIN_RST = 16'h8000;
   localparam logic [GAIN_W-1:0] OFFSET_RST = 16'h0000;
   localparam logic [LIM_W-1:0] HIGH_RST = 12'hfff;
   localparam logic [LIM_W-1:0] LOW_RST = 12'h000;
   // timing
   localparam int CLK_PERIOD_NS = 10;
   localparam int AUTO_PERIOD_NS = 1000; // internal trigger period
   localparam int AUTO_PERIOD_CYC = AUTO_PERIOD_NS / CLK_PERIOD_NS;
   // channel config word: bit3 bipolar, bit2 check enable, 1:0 ratio code
   typedef struct packed {
      logic bipolar;
      logic limit_check_enable;
      logic [1:0] averaging_ratio_field; // 0:1 1:4 2:16 3:64
   } arpp_cfg_t;
   typedef enum logic {ARPP_IDLE, ARPP_ACCUM} arpp_phase_t;
endpackage

// *** testbench/arpp_top_chk.sv ***
// assertions on the post-processing ports
// assumes a bind into arpp_top, one clock
`timescale 1ns/1ps
`default_nettype none
module arpp_top_chk import arpp_pkg::*; #(
   parameter int FIFO_DEPTH = FIFO_DEPTH_DEF,
   parameter int AUTO_CYC = AUTO_PERIOD_CYC
) (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_nrst,
   // watched ports
   input wire logic o_convert_trigger,
   input wire logic o_mux_lock,
   input wire logic [CH_W-1:0] o_mux_chan,
   input wire logic o_res_valid,
   input wire logic i_res_ready,
   input wire logic [RES_W-1:0] o_res_data,
   input wire logic [1:0] o_res_ratio,
   input wire logic o_busy,
   input wire logic o_any_limit_alert,
   input wire logic i_reg_cfg_mode,
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   input wire logic [REG_DATA_W-1:0] o_reg_rdata,
   input wire logic o_reg_rvalid
);
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_nrst);
   // above the ratio's width: zeros, or copies of a set sign bit
   // unipolar results may use their top bit, so only bits past it must be 0
   function automatic logic ext_ok(input logic [RES_W-1:0] d,
      input logic [1:0] k);
      logic [RES_W-1:0] top;
      top = d >> (15 + k);
      return ((top >> 1) == '0) || (top == ({RES_W{1'b1}} >> (15 + k)));
   endfunction
   AST_WIDTH: assert property (o_res_valid |->
      ext_ok(o_res_data, o_res_ratio)) else $error("result width wrong");
   AST_HOLD: assert property (o_res_valid && !i_res_ready |=>
      o_res_valid && $stable(o_res_data)) else $error("result dropped");
   AST_LOCK_CHAN: assert property (o_mux_lock ##1 o_mux_lock |->
      $stable(o_mux_chan)) else $error("held channel moved");
   AST_UNLOCK: assert property ($fell(o_mux_lock) |-> o_res_valid)
      else $error("lock ended without result");
   AST_BUSY_FALL: assert property ($fell(o_busy) |->
      o_res_valid || $past(i_reg_wr)) else $error("busy fell early");
   AST_ALERT_RISE: assert property ($rose(o_any_limit_alert) |->
      o_res_valid) else $error("alert rose without result");
   AST_ALERT_FALL: assert property ($fell(o_any_limit_alert) |->
      o_res_valid || o_reg_rvalid) else $error("alert fell unprompted");
   AST_RD_ANSWER: assert property (i_reg_rd |=> o_reg_rvalid)
      else $error("read not answered");
   AST_RD_CFG: assert property (i_reg_rd && !i_reg_cfg_mode |=>
      o_reg_rdata == 16'h0000) else $error("read outside config mode");
   AST_TRIG: assert property (o_convert_trigger |=>
      !o_convert_trigger [*3]) else $error("triggers too close");
   // main scenarios reached
   cover property (o_res_valid && i_res_ready && o_res_ratio == 2'h3);
   cover property ($fell(o_any_limit_alert) && !o_reg_rvalid);
   cover property ($fell(o_busy));
endmodule
bind arpp_top arpp_top_chk #(.FIFO_DEPTH(FIFO_DEPTH),
   .AUTO_CYC(AUTO_CYC)) arpp_top_chk_i (.*);
`default_nettype wire

// *** testbench/arpp_sink.sv ***
// result sink standing in for the reading host
// assumes the valid/ready result handshake of arpp_top
`timescale 1ns/1ps
`default_nettype none
module arpp_sink (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_nrst,
   // 0 prompt, 1 random stalls, 2 hold off
   input wire logic [1:0] i_mode,
   // result handshake
   output logic o_res_ready
);
   logic [15:0] lfsr; // stall pattern
   // ready moves only just after an edge
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         lfsr <= 16'hace1;
         o_res_ready <= 1'b0;
      end else begin
         lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
         o_res_ready <= (i_mode == 2'h0) || (i_mode == 2'h1 && lfsr[0]);
      end
   end
endmodule
`default_nettype wire

// *** testbench/adc_result_postprocess_test.sv ***
// self-checking bench for the result post-processing path
// assumes arpp_top, the sink model and the checker compiled first
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin failures++; \
   $display("ERROR %0t: got %h want %h", $time, a, b); end end
module adc_result_postprocess_test import arpp_pkg::*;;
   // design connections
   logic i_clk, i_nrst, i_smp_valid, o_smp_ready, o_convert_trigger;
   logic o_mux_lock, o_res_valid, i_res_ready, o_busy, o_any_limit_alert;
   logic i_reg_cfg_mode, i_reg_wr, i_reg_rd, o_reg_rvalid;
   logic [CH_W-1:0] i_smp_chan, o_mux_chan, o_res_chan;
   logic [SMP_W-1:0] i_smp_data;
   logic [RES_W-1:0] o_res_data;
   logic [1:0] o_res_ratio, sink_mode;
   logic [REG_ADDR_W-1:0] i_reg_addr;
   logic [REG_DATA_W-1:0] i_reg_wdata, o_reg_rdata, smp_q[$];
   logic [23:0] res_q[$], got; // chan, ratio, data
   logic [31:0] seed; // xorshift state
   int failures, n_compared, cycles, n;
   // short trigger period keeps the run brief
   arpp_top #(.AUTO_CYC(4)) arpp_top_i (.*);
   arpp_sink arpp_sink_i (.i_clk(i_clk), .i_nrst(i_nrst),
      .i_mode(sink_mode), .o_res_ready(i_res_ready));
   initial begin
      i_clk = 1'b0;
      forever #5 i_clk = ~i_clk;
   end
   // collect every taken result, pre-edge values
   always @(posedge i_clk) begin
      cycles++;
      if (i_nrst && o_res_valid && i_res_ready)
         res_q.push_back({o_res_chan, o_res_ratio, o_res_data});
      if (cycles == 20000) begin
         failures++;
         $display("ERROR %0t: run hung", $time);
         conclude();
      end
   end
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic conclude();
      $display("compared %0d, failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic wr(input int a, input logic [15:0] d);
      i_reg_wr <= 1'b1;
      i_reg_addr <= a[6:0];
      i_reg_wdata <= d;
      @(posedge i_clk);
      i_reg_wr <= 1'b0;
      @(posedge i_clk);
   endtask
   // read and compare, answer one cycle on
   task automatic rd(input int a, input logic [15:0] e);
      i_reg_rd <= 1'b1;
      i_reg_addr <= a[6:0];
      @(posedge i_clk);
      i_reg_rd <= 1'b0;
      @(negedge i_clk);
      `CHK({o_reg_rvalid, o_reg_rdata}, {1'b1, e})
      @(posedge i_clk);
   endtask
   task automatic wait_res(input int cnt);
      int t;
      t = 0;
      while (res_q.size() < cnt && t < 3000) begin
         @(posedge i_clk);
         t++;
      end
   endtask
   // expected unipolar result: average, offset, gain, then clamp
   function automatic longint exp_res(longint sum, int k, g, o);
      longint v;
      v = (((sum >> k) + ($signed(o[15:0]) >>> (3 - k))) * g) >>> 15;
      if (v < 0)
         v = 0;
      if (v >= (longint'(1) << (16 + k)))
         v = (longint'(1) << (16 + k)) - 1;
      return v;
   endfunction
   // one averaged result: random samples in lo..hi, expectation computed
   task automatic run(input int ch, k, g, o, lo, hi);
      longint sum, v;
      sum = 0;
      smp_q = {};
      wr(ch * 8 + 1, g[15:0]);
      wr(ch * 8 + 2, o[15:0]);
      repeat (1 << (2 * k)) begin
         smp_q.push_back(16'(lo + (rnd() % (hi - lo + 1))));
         sum += smp_q[$];
      end
      foreach (smp_q[i]) begin
         i_smp_valid <= 1'b1;
         i_smp_chan <= ch[2:0];
         i_smp_data <= smp_q[i];
         do @(posedge i_clk); while (!o_smp_ready);
      end
      i_smp_valid <= 1'b0;
      wait_res(1);
      v = exp_res(sum, k, g, o);
      got = res_q.pop_front();
      `CHK(got, {ch[2:0], k[1:0], v[18:0]})
   endtask
   initial begin
      seed = 32'hab15;
      i_nrst = 1'b0;
      i_smp_valid = 1'b0;
      i_smp_chan = 3'h0;
      i_smp_data = 16'h0000;
      i_reg_cfg_mode = 1'b1;
      i_reg_wr = 1'b0;
      i_reg_rd = 1'b0;
      i_reg_addr = 7'h00;
      i_reg_wdata = 16'h0000;
      sink_mode = 2'h0;
      repeat (20) @(posedge i_clk);
      i_nrst <= 1'b1;
      @(posedge i_clk);
      // reset words of every channel, plus an unmapped slot
      for (int c = 0; c < CH; c++) begin
         rd(c * 8 + 1, GAIN_RST);
         rd(c * 8 + 2, OFFSET_RST);
         rd(c * 8 + 6, 16'h0000);
      end
      rd(REG_SETUP, 16'h0000);
      // advanced sequencer, own ratio per channel, then with stalls
      wr(REG_SETUP, 16'h0009);
      for (int r = 0; r < 2; r++) begin
         sink_mode <= 2'(r);
         for (int k = 0; k < 4; k++) begin
            wr((k + 1) * 8, k[15:0]);
            run(k + 1, k, rnd() % 32768, rnd(), 4096, 32767);
         end
      end
      // standard sequencer: channel zero rules ratio and checking
      wr(REG_SETUP, 16'h0008);
      wr(0, 16'h0006);
      wr(48, 16'h0000);
      wr(52, 16'h0fff);
      run(6, 2, 32768, 0, 0, 65535);
      `CHK(o_any_limit_alert, 1'b1)
      rd(REG_ALERT_B, 16'h0040);
      // saturation at full scale
      wr(REG_SETUP, 16'h0009);
      wr(56, 16'h0000);
      run(7, 0, 65535, 32767, 65000, 65535);
      // limits on channel two, exact boundaries
      wr(16, 16'h0004);
      wr(19, 16'h0800);
      wr(20, 16'h0100);
      wr(21, 16'h0010);
      run(2, 0, 32768, 0, 32768, 32768);
      `CHK(o_any_limit_alert, 1'b1)
      rd(REG_ALERT_A, 16'h0004);
      rd(REG_ALERT_A, 16'h0000);
      run(2, 0, 32768, 0, 4096, 4096);
      i_reg_cfg_mode <= 1'b0;
      rd(REG_ALERT_B, 16'h0000);
      i_reg_cfg_mode <= 1'b1;
      run(2, 0, 32768, 0, 4352, 4352);
      `CHK(o_any_limit_alert, 1'b1)
      run(2, 0, 32768, 0, 4353, 4353);
      `CHK(o_any_limit_alert, 1'b0)
      // command mode after the host zeroes channel three's ratio; read-only clearing
      wr(24, 16'h0000);
      wr(REG_SETUP, 16'h000f);
      run(3, 0, rnd() % 65536, rnd(), 0, 65535);
      run(2, 0, 32768, 0, 4096, 4096);
      run(2, 0, 32768, 0, 4353, 4353);
      `CHK(o_any_limit_alert, 1'b1)
      rd(REG_ALERT_B, 16'h0004);
      // sink holds off until the buffer refuses, then drains
      sink_mode <= 2'h2;
      wr(8, 16'h0000);
      wr(9, 16'h8000);
      wr(10, 16'h0000);
      n = 0;
      i_smp_valid <= 1'b1;
      i_smp_chan <= 3'h1;
      repeat (20) begin
         i_smp_data <= 16'(n * 64);
         @(posedge i_clk);
         if (o_smp_ready)
            n++;
      end
      i_smp_valid <= 1'b0;
      `CHK(n >= FIFO_DEPTH_DEF && n < 20, 1'b1)
      sink_mode <= 2'h0;
      wait_res(n);
      for (int i = 0; i < n; i++) begin
         got = res_q.pop_front();
         `CHK(got, {3'h1, 2'h0, 19'(i * 64)})
      end
      // internal triggers every four cycles
      wr(REG_SETUP, 16'h0019);
      repeat (8) @(posedge i_clk);
      n = 0;
      repeat (40) begin
         @(posedge i_clk);
         if (o_convert_trigger)
            n++;
      end
      `CHK(n, 10)
      conclude();
   end
endmodule
`default_nettype wire
